// ===== design/flash_write_erase_controller.sv
// Operation
// - array of 32 pages, 1024 bytes each
// - programming uses 14-bit word address
// - high address bits 5:1 pick page
// - erase clears page chosen by bits 5:1
// - programming only clears bits to zero
// - erased page reads all ones
// - write start begins single or block program
// - first byte low, second byte programs word
// - word busy high during each word program
// - word program 20 us, erase 20 ms
// - 40 us without byte pair aborts
// - abort keeps failing address for resume
// - dma trigger when data port ready
// - write start issues first dma trigger
// - erase start sets busy until done
// - erase completes before write sequence
// - stall cpu when started from flash
// - chip reset holds block reset; array contents kept
// - timing value scales generator, reset 0x11
`timescale 1ns/1ps
module flash_write_erase_controller
    import flash_ctrl_pkg::*;
#(
    parameter int ERASE_TICKS = PAGE_ERASE_TICKS
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        codeRdEn,
    input  wire logic [14:0] codeRdAddr,
    output logic      [7:0]  codeRdData,
    input  wire logic        fetchFromFlash,
    output logic             cpuStall,
    output logic             accessViolation,
    output logic             dmaTrigger,
    output logic      [4:0]  dmaTriggerCode,
    output logic             continuousRead
);

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    function automatic logic hitReg(input logic [7:0] idx, input logic [7:0] want);
        hitReg = (idx == want);
    endfunction : hitReg

    localparam logic [15:0] ERASE_LAST = 16'(ERASE_TICKS - 1);
    localparam logic [8:0]  SWEEP_LAST = 9'(PAGE_WORDS - 1);

    logic [7:0]   regIdx;
    logic         busWrite;
    logic         busPrep;
    logic         wrStart;
    logic         erStart;
    logic         dataWr;
    logic         tick;
    logic [5:0]   timingEff;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    flash_state_t state_reg, state_next;
    logic [7:0]   ctrlAddrHigh_reg, ctrlAddrHigh_next;
    logic [7:0]   ctrlAddrLow_reg, ctrlAddrLow_next;
    logic [5:0]   timing_reg, timing_next;
    logic [7:0]   wdata_reg, wdata_next;
    logic [7:0]   lowByte_reg, lowByte_next;
    logic         phase_reg, phase_next;
    logic         pendWrite_reg, pendWrite_next;
    logic         contRd_reg, contRd_next;
    logic         stallSrc_reg, stallSrc_next;
    logic [5:0]   prescale_reg, prescale_next;
    logic [15:0]  tickCnt_reg, tickCnt_next;
    logic [8:0]   sweep_reg, sweep_next;
    logic         sweepDone_reg, sweepDone_next;
    logic         trig_reg, trig_next;
    logic         ack_reg, ack_next;
    logic [31:0]  rdat_reg, rdat_next;

    logic         busy;
    logic         wordBusy;
    logic [13:0]  wordAddr;
    logic         memWe;
    logic [13:0]  memAddr;
    logic [15:0]  memData;
    logic [15:0]  oldWord;
    logic [15:0]  mem [WORD_COUNT];

    assign busy     = (state_reg != ST_IDLE);
    assign wordBusy = (state_reg == ST_PROGRAM);
    assign wordAddr = {ctrlAddrHigh_reg[5:0], ctrlAddrLow_reg};
    assign oldWord  = mem[wordAddr];

    assign regIdx   = wb_adr_i[9:2];
    assign busWrite = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];
    assign busPrep  = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wrStart  = busWrite & hitReg(regIdx, IDX_CTRL) & wb_dat_i[CTRL_WRITE_BIT];
    assign erStart  = busWrite & hitReg(regIdx, IDX_CTRL) & wb_dat_i[CTRL_ERASE_BIT];
    assign dataWr   = busWrite & hitReg(regIdx, IDX_WDATA);

    // ----------------------------------------------------------------
    // timing generator
    // ----------------------------------------------------------------
    // a zero timing value would stop the generator, so it counts as one
    assign timingEff = (timing_reg == 6'h00) ? 6'h01 : timing_reg;
    assign tick      = (prescale_reg == timingEff - 6'h01);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_next        = state_reg;
        ctrlAddrHigh_next = ctrlAddrHigh_reg;
        ctrlAddrLow_next  = ctrlAddrLow_reg;
        timing_next       = timing_reg;
        wdata_next        = wdata_reg;
        lowByte_next      = lowByte_reg;
        phase_next        = phase_reg;
        pendWrite_next    = pendWrite_reg;
        contRd_next       = contRd_reg;
        stallSrc_next     = stallSrc_reg;
        prescale_next     = tick ? 6'h00 : prescale_reg + 6'h01;
        tickCnt_next      = tick ? tickCnt_reg + 16'h0001 : tickCnt_reg;
        sweep_next        = sweep_reg;
        sweepDone_next    = sweepDone_reg;
        trig_next         = 1'b0;
        memWe             = 1'b0;
        memAddr           = wordAddr;
        memData           = oldWord;

        if (busWrite) begin
            if (hitReg(regIdx, IDX_ADDRH)) begin
                ctrlAddrHigh_next = wb_dat_i[7:0];
            end
            if (hitReg(regIdx, IDX_ADDRL)) begin
                ctrlAddrLow_next = wb_dat_i[7:0];
            end
            if (hitReg(regIdx, IDX_TIMING)) begin
                timing_next = wb_dat_i[5:0];
            end
            if (hitReg(regIdx, IDX_CTRL)) begin
                contRd_next = wb_dat_i[CTRL_CONTRD_BIT];
            end
            if (dataWr) begin
                wdata_next = wb_dat_i[7:0];
            end
        end

        case (state_reg)
            ST_IDLE: begin
                phase_next = 1'b0;
                if (erStart) begin
                    state_next     = ST_ERASE;
                    pendWrite_next = wrStart;
                    stallSrc_next  = fetchFromFlash;
                    tickCnt_next   = 16'h0000;
                    sweep_next     = 9'h000;
                    sweepDone_next = 1'b0;
                end else if (wrStart) begin
                    state_next    = ST_WAIT_DATA;
                    stallSrc_next = fetchFromFlash;
                    tickCnt_next  = 16'h0000;
                    trig_next     = 1'b1;
                end
            end
            ST_ERASE: begin
                // the page is cleared one word per clock, well inside the erase time
                if (!sweepDone_reg) begin
                    memWe      = 1'b1;
                    memAddr    = {ctrlAddrHigh_reg[5:1], sweep_reg};
                    memData    = ERASED_WORD;
                    sweep_next = sweep_reg + 9'h001;
                    if (sweep_reg == SWEEP_LAST) begin
                        sweepDone_next = 1'b1;
                    end
                end
                if (tick && tickCnt_reg >= ERASE_LAST && sweepDone_reg) begin
                    tickCnt_next   = 16'h0000;
                    pendWrite_next = 1'b0;
                    if (pendWrite_reg) begin
                        state_next = ST_WAIT_DATA;
                        trig_next  = 1'b1;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_WAIT_DATA: begin
                if (dataWr && !phase_reg) begin
                    lowByte_next = wb_dat_i[7:0];
                    phase_next   = 1'b1;
                    trig_next    = 1'b1;
                end else if (dataWr) begin
                    memWe        = 1'b1;
                    memData      = oldWord & {wb_dat_i[7:0], lowByte_reg};
                    phase_next   = 1'b0;
                    state_next   = ST_PROGRAM;
                    tickCnt_next = 16'h0000;
                end else if (tick && tickCnt_reg >= TIMEOUT_TICKS - 16'h0001) begin
                    // address is left alone so a fresh start resumes here
                    state_next = ST_IDLE;
                    phase_next = 1'b0;
                end
            end
            ST_PROGRAM: begin
                if (tick && tickCnt_reg >= WORD_PROG_TICKS - 16'h0001) begin
                    {ctrlAddrHigh_next[5:0], ctrlAddrLow_next} = wordAddr + 14'h0001;
                    state_next   = ST_WAIT_DATA;
                    tickCnt_next = 16'h0000;
                    trig_next    = 1'b1;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg        <= ST_IDLE;
            ctrlAddrHigh_reg <= ADDRH_RESET;
            ctrlAddrLow_reg  <= ADDRL_RESET;
            timing_reg       <= TIMING_RESET;
            wdata_reg        <= WDATA_RESET;
            lowByte_reg      <= 8'h00;
            phase_reg        <= 1'b0;
            pendWrite_reg    <= 1'b0;
            contRd_reg       <= 1'b0;
            stallSrc_reg     <= 1'b0;
            prescale_reg     <= 6'h00;
            tickCnt_reg      <= 16'h0000;
            sweep_reg        <= 9'h000;
            sweepDone_reg    <= 1'b0;
            trig_reg         <= 1'b0;
        end else begin
            state_reg        <= state_next;
            ctrlAddrHigh_reg <= ctrlAddrHigh_next;
            ctrlAddrLow_reg  <= ctrlAddrLow_next;
            timing_reg       <= timing_next;
            wdata_reg        <= wdata_next;
            lowByte_reg      <= lowByte_next;
            phase_reg        <= phase_next;
            pendWrite_reg    <= pendWrite_next;
            contRd_reg       <= contRd_next;
            stallSrc_reg     <= stallSrc_next;
            prescale_reg     <= prescale_next;
            tickCnt_reg      <= tickCnt_next;
            sweep_reg        <= sweep_next;
            sweepDone_reg    <= sweepDone_next;
            trig_reg         <= trig_next;
        end
    end

    // ----------------------------------------------------------------
    // wishbone slave: one wait state, unmapped reads give zero
    // ----------------------------------------------------------------
    always_comb begin
        ack_next  = busPrep;
        rdat_next = rdat_reg;
        if (busPrep) begin
            rdat_next = 32'h0000_0000;
            case (regIdx)
                IDX_CTRL: begin
                    rdat_next[CTRL_BUSY_BIT]   = busy;
                    rdat_next[CTRL_WBUSY_BIT]  = wordBusy;
                    rdat_next[CTRL_CONTRD_BIT] = contRd_reg;
                end
                IDX_WDATA:  rdat_next[7:0] = wdata_reg;
                IDX_ADDRH:  rdat_next[7:0] = ctrlAddrHigh_reg;
                IDX_ADDRL:  rdat_next[7:0] = ctrlAddrLow_reg;
                IDX_TIMING: rdat_next[5:0] = timing_reg;
                default:    rdat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    // ----------------------------------------------------------------
    // array and code read port
    // ----------------------------------------------------------------
    logic [7:0] codeData_reg;
    logic       violation_reg;

    always_ff @(posedge ref_clk) begin
        if (memWe) begin
            mem[memAddr] <= memData;
        end
    end

    // reads are byte addressed; a read during a word program is flagged
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            codeData_reg  <= 8'h00;
            violation_reg <= 1'b0;
        end else begin
            violation_reg <= codeRdEn & wordBusy;
            if (codeRdEn) begin
                codeData_reg <= codeRdAddr[0] ? mem[codeRdAddr[14:1]][15:8]
                                              : mem[codeRdAddr[14:1]][7:0];
            end
        end
    end

    assign wb_ack_o        = ack_reg;
    assign wb_dat_o        = rdat_reg;
    assign codeRdData      = codeData_reg;
    assign accessViolation = violation_reg;
    assign dmaTrigger      = trig_reg;
    assign dmaTriggerCode  = FLASH_TRIGGER_CODE;
    assign continuousRead  = contRd_reg;
    assign cpuStall        = busy & stallSrc_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_ack_after_req: assert property (busPrep |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single pulse after request");
    a_first_trigger: assert property (
        (state_reg == ST_IDLE && wrStart && !erStart) |=> dmaTrigger && busy)
        else $error("write start gave no first trigger");
    a_erase_first: assert property (
        (state_reg == ST_IDLE && wrStart && erStart) |=> state_reg == ST_ERASE && !dmaTrigger)
        else $error("erase not run before write");
    a_erase_ones: assert property (
        (memWe && state_reg == ST_ERASE) |-> memData == ERASED_WORD
            && memAddr[13:9] == ctrlAddrHigh_reg[5:1])
        else $error("erase wrote wrong data or page");
    a_only_clears: assert property (
        (memWe && state_reg == ST_WAIT_DATA) |-> (memData & ~oldWord) == 16'h0000)
        else $error("program set a bit");
    a_word_busy_span: assert property (
        $rose(wordBusy) |-> wordBusy [*8])
        else $error("word program ended too soon");
    a_addr_advance: assert property (
        $fell(wordBusy) |-> wordAddr == $past(wordAddr) + 14'h0001)
        else $error("address did not advance");
    a_timeout_keep: assert property (
        ($past(state_reg) == ST_WAIT_DATA && state_reg == ST_IDLE)
            |-> wordAddr == $past(wordAddr))
        else $error("address changed on abort");
    a_stall_busy: assert property (
        (state_reg == ST_IDLE && (wrStart || erStart) && fetchFromFlash) |=> cpuStall)
        else $error("start from flash did not stall");
    a_violation_flag: assert property (codeRdEn && wordBusy |=> accessViolation)
        else $error("access during program not flagged");

endmodule : flash_write_erase_controller

// ===== inc/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_TIMING = 8'hab;
    localparam logic [7:0] IDX_ADDRL  = 8'hac;
    localparam logic [7:0] IDX_ADDRH  = 8'had;
    localparam logic [7:0] IDX_CTRL   = 8'hae;
    localparam logic [7:0] IDX_WDATA  = 8'haf;

    // ----------------------------------------------------------------
    // control byte fields
    // ----------------------------------------------------------------
    localparam int CTRL_BUSY_BIT   = 7;
    localparam int CTRL_WBUSY_BIT  = 6;
    localparam int CTRL_CONTRD_BIT = 4;
    localparam int CTRL_WRITE_BIT  = 1;
    localparam int CTRL_ERASE_BIT  = 0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [5:0] TIMING_RESET = 6'h11;
    localparam logic [7:0] ADDRH_RESET  = 8'h00;
    localparam logic [7:0] ADDRL_RESET  = 8'h00;
    localparam logic [7:0] WDATA_RESET  = 8'h00;

    // ----------------------------------------------------------------
    // array geometry
    // ----------------------------------------------------------------
    localparam int PAGE_COUNT = 32;
    localparam int PAGE_BYTES = 1024;
    localparam int PAGE_WORDS = PAGE_BYTES / 2;
    localparam int WORD_COUNT = PAGE_COUNT * PAGE_WORDS;
    localparam logic [15:0] ERASED_WORD = 16'hffff;

    // ----------------------------------------------------------------
    // timing: the generator ticks once per timing-value clocks
    // ----------------------------------------------------------------
    // one tick is 21000/16 ns whatever the clock, once the timing value matches it
    localparam longint TICK_PS       = (64'd21000 * 64'd1000) / 64'd16;
    localparam longint WORD_PROG_PS  = 64'd20000000;
    localparam longint PAGE_ERASE_PS = 64'd20000000000;
    localparam longint TIMEOUT_PS    = 64'd40000000;
    localparam logic [15:0] WORD_PROG_TICKS =
        16'((WORD_PROG_PS + TICK_PS - 64'd1) / TICK_PS);
    localparam int PAGE_ERASE_TICKS = int'((PAGE_ERASE_PS + TICK_PS - 64'd1) / TICK_PS);
    localparam logic [15:0] TIMEOUT_TICKS = 16'(TIMEOUT_PS / TICK_PS);

    localparam logic [4:0] FLASH_TRIGGER_CODE = 5'h12;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_ERASE     = 2'b01,
        ST_WAIT_DATA = 2'b10,
        ST_PROGRAM   = 2'b11
    } flash_state_t;

endpackage : flash_ctrl_pkg

// ===== sim/cpu_dma_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// bus master standing for the cpu and a dma channel
// ----------------------------------------------------------------
module cpu_dma_model
    import flash_ctrl_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        wb_ack_o,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        dmaTrigger,
    output logic             wb_cyc_i,
    output logic             wb_stb_i,
    output logic             wb_we_i,
    output logic      [9:0]  wb_adr_i,
    output logic      [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_i
);
    logic [7:0] src [0:3] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
    logic [7:0] dmaRd;
    int         dmaLeft = 0;
    int         srcIdx  = 0;

    initial begin
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i  = 1'b0;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h00000000;
    end

    // request held until the edge that sees ack; released only after it
    task automatic wbCycle(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                           output logic [7:0] rd);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'hf;
        wb_dat_i <= {24'h000000, wd};
        // no wait is assumed; only the bench watchdog ends a stuck cycle
        do begin
            @(posedge ref_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wbCycle

    // single byte moves, source steps, destination fixed; count kept even
    initial forever begin
        @(posedge ref_clk);
        if (dmaTrigger === 1'b1 && dmaLeft > 0) begin
            wbCycle(1'b1, IDX_WDATA, src[srcIdx], dmaRd);
            srcIdx++;
            dmaLeft--;
        end
    end
endmodule : cpu_dma_model

// ===== sim/tb_flash_write_erase_controller.sv
`timescale 1ns/1ps
module tb_flash_write_erase_controller
    import flash_ctrl_pkg::*;
;
    typedef struct {logic we; logic [7:0] idx; logic [7:0] dat; logic [7:0] exp;} row_t;
    logic        ref_clk;
    logic        resetn;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        codeRdEn, fetchFromFlash, cpuStall, accessViolation;
    logic [14:0] codeRdAddr;
    logic [7:0]  codeRdData, rd;
    logic        dmaTrigger, continuousRead;
    logic [4:0]  dmaTriggerCode;
    int          fails = 0;
    int          checked = 0;
    row_t        rows [13] = '{
        '{1'b0, IDX_TIMING, 8'h00, 8'h11},
        '{1'b0, IDX_ADDRL, 8'h00, 8'h00},
        '{1'b0, IDX_ADDRH, 8'h00, 8'h00},
        '{1'b0, IDX_CTRL, 8'h00, 8'h00},
        '{1'b0, IDX_WDATA, 8'h00, 8'h00},
        '{1'b1, 8'h10, 8'h55, 8'h00},
        '{1'b0, 8'h10, 8'h00, 8'h00},
        '{1'b1, IDX_TIMING, 8'h01, 8'h00},
        '{1'b0, IDX_TIMING, 8'h00, 8'h01},
        '{1'b1, IDX_CTRL, 8'h10, 8'h00},
        '{1'b0, IDX_CTRL, 8'h00, 8'h10},
        '{1'b1, IDX_ADDRH, 8'h02, 8'h00},
        '{1'b0, IDX_ADDRH, 8'h00, 8'h02}};

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    cpu_dma_model i_cpu_dma_model (.ref_clk(ref_clk), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .dmaTrigger(dmaTrigger), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));

    // short erase keeps the run brief; the sweep still walks all 512 words
    flash_write_erase_controller #(.ERASE_TICKS(2)) i_flash_write_erase_controller (
        .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .codeRdEn(codeRdEn),
        .codeRdAddr(codeRdAddr), .codeRdData(codeRdData), .fetchFromFlash(fetchFromFlash),
        .cpuStall(cpuStall), .accessViolation(accessViolation), .dmaTrigger(dmaTrigger),
        .dmaTriggerCode(dmaTriggerCode), .continuousRead(continuousRead));

    // ----------------------------------------------------------------
    // compare and bus helpers
    // ----------------------------------------------------------------
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkByte

    task automatic checkBit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : checkBit

    task automatic regWr(input logic [7:0] idx, input logic [7:0] d);
        i_cpu_dma_model.wbCycle(1'b1, idx, d, rd);
    endtask : regWr

    task automatic regRd(input logic [7:0] idx, input logic [7:0] exp);
        i_cpu_dma_model.wbCycle(1'b0, idx, 8'h00, rd);
        checkByte(rd, exp);
    endtask : regRd

    task automatic codeRd(input logic [14:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        codeRdEn   <= 1'b1;
        codeRdAddr <= a;
        @(posedge ref_clk);
        codeRdEn <= 1'b0;
        #1 checkByte(codeRdData, exp);
    endtask : codeRd

    // polls the busy flag; a hang shows as busy still set
    task automatic waitIdle();
        int n;
        n = 0;
        do begin
            i_cpu_dma_model.wbCycle(1'b0, IDX_CTRL, 8'h00, rd);
            n++;
        end while (rd[CTRL_BUSY_BIT] !== 1'b0 && n < 400);
        checkBit(rd[CTRL_BUSY_BIT], 1'b0);
    endtask : waitIdle

    task automatic test_done();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        test_done();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        codeRdEn = 1'b0;
        codeRdAddr = 15'h0000;
        fetchFromFlash = 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            if (rows[i].we) regWr(rows[i].idx, rows[i].dat);
            else regRd(rows[i].idx, rows[i].exp);
        end
        checkBit(continuousRead, 1'b1);
        checkByte({3'b000, dmaTriggerCode}, 8'h12);
        // erase page 1 and block-program it by dma from one start
        fetchFromFlash <= 1'b1;
        i_cpu_dma_model.dmaLeft = 4;
        regWr(IDX_CTRL, 8'h03);
        // the bus stays quiet after the erase start, as a no-op would
        repeat (100) @(posedge ref_clk);
        #1 checkBit(cpuStall, 1'b1);
        checkBit(i_cpu_dma_model.dmaLeft == 4, 1'b1);
        for (int n = 0; n < 3000 && i_cpu_dma_model.dmaLeft > 0; n++) @(posedge ref_clk);
        checkBit(i_cpu_dma_model.dmaLeft == 0, 1'b1);
        waitIdle();
        checkBit(cpuStall, 1'b0);
        fetchFromFlash <= 1'b0;
        regRd(IDX_ADDRL, 8'h02);
        codeRd(15'h0400, 8'h5a);
        codeRd(15'h0401, 8'ha5);
        codeRd(15'h0402, 8'h3c);
        codeRd(15'h0403, 8'hc3);
        codeRd(15'h0404, 8'hff);
        codeRd(15'h07ff, 8'hff);
        // cpu writes over stored data, then a lone byte runs out the timer
        regWr(IDX_ADDRL, 8'h00);
        regWr(IDX_CTRL, 8'h02);
        regWr(IDX_WDATA, 8'h0f);
        regWr(IDX_WDATA, 8'hff);
        @(posedge ref_clk);
        codeRdEn <= 1'b1;
        @(posedge ref_clk);
        codeRdEn <= 1'b0;
        #1 checkBit(accessViolation, 1'b1);
        regRd(IDX_CTRL, 8'hc0);
        repeat (20) @(posedge ref_clk);
        regRd(IDX_CTRL, 8'h80);
        regWr(IDX_WDATA, 8'h00);
        waitIdle();
        regRd(IDX_ADDRL, 8'h01);
        codeRd(15'h0400, 8'h0a);
        codeRd(15'h0401, 8'ha5);
        codeRd(15'h0402, 8'h3c);
        // reset in mid-run
        resetn <= 1'b0;
        @(posedge ref_clk);
        checkByte(codeRdData, 8'h00);
        resetn <= 1'b1;
        regRd(IDX_TIMING, 8'h11);
        regRd(IDX_ADDRL, 8'h00);
        test_done();
    end
endmodule : tb_flash_write_erase_controller
